/* File: rtl/hts_pkg.sv */
// constants shared by the humidity and temperature sensor core
package hts_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int CLK_PER_MS    = CLK_HZ / 1_000;
  localparam int MEAS_HIGH_US  = 8300;
  localparam int MEAS_MED_US   = 4500;
  localparam int MEAS_LOW_US   = 2000;
  localparam int HEAT_LONG_MS  = 1000;
  localparam int HEAT_SHORT_MS = 100;
  localparam int MEAS_HIGH_CYC = MEAS_HIGH_US * CLK_PER_US;
  localparam int MEAS_MED_CYC  = MEAS_MED_US * CLK_PER_US;
  localparam int MEAS_LOW_CYC  = MEAS_LOW_US * CLK_PER_US;
  localparam int HEAT_LONG_CYC = HEAT_LONG_MS * CLK_PER_MS;
  localparam int HEAT_SHORT_CYC = HEAT_SHORT_MS * CLK_PER_MS;
  localparam int CNT_W         = 25;

  // ****************************************************************
  // bus addresses and command codes
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
  localparam logic [6:0] GC_ADDR          = 7'h00;
  localparam logic [7:0] GC_RESET         = 8'h06;
  localparam logic [7:0] CMD_MEAS_HIGH    = 8'hfd;
  localparam logic [7:0] CMD_MEAS_MED     = 8'hf6;
  localparam logic [7:0] CMD_MEAS_LOW     = 8'he0;
  localparam logic [7:0] CMD_SERIAL       = 8'h89;
  localparam logic [7:0] CMD_SOFT_RST     = 8'h94;
  localparam logic [7:0] CMD_HEAT_200_L   = 8'h39;
  localparam logic [7:0] CMD_HEAT_200_S   = 8'h32;
  localparam logic [7:0] CMD_HEAT_110_L   = 8'h2f;
  localparam logic [7:0] CMD_HEAT_110_S   = 8'h24;
  localparam logic [7:0] CMD_HEAT_20_L    = 8'h1e;
  localparam logic [7:0] CMD_HEAT_20_S    = 8'h15;
  localparam logic [7:0] IDLE_BYTE        = 8'hff;
  localparam logic [2:0] TX_LAST          = 3'h5;

  // ****************************************************************
  // heater power levels
  // ****************************************************************
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_20  = 2'h1;
  localparam logic [1:0] LVL_110 = 2'h2;
  localparam logic [1:0] LVL_200 = 2'h3;

  // ****************************************************************
  // checksum
  // ****************************************************************
  localparam logic [7:0]  CRC_POLY       = 8'h31;
  localparam logic [7:0]  CRC_INIT       = 8'hff;
  localparam logic [15:0] CRC_CHECK_WORD = 16'hbeef;
  localparam logic [7:0]  CRC_CHECK_VAL  = 8'h92;

  // value is arbitrary
  localparam logic [31:0] SERIAL_DEFAULT = 32'h1357_9bdf;

endpackage : hts_pkg

/* File: rtl/hts_crc8.sv */
// crc-8 over one 16-bit word, msb first
`timescale 1ns/1ns
`default_nettype none
module hts_crc8 (
  input  wire logic [15:0] data_i,
  output logic      [7:0]  crc_o
);

  always_comb begin
    crc_o = hts_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc_o[7] ^ data_i[i]) begin
        crc_o = {crc_o[6:0], 1'b0} ^ hts_pkg::CRC_POLY;
      end else begin
        crc_o = {crc_o[6:0], 1'b0};
      end
    end
  end

endmodule : hts_crc8
`default_nettype wire

/* File: rtl/hts_sensor_core.sv */
// serial-bus command core of the humidity and temperature sensor
`timescale 1ns/1ns
`default_nettype none
module hts_sensor_core #(
  parameter int          MEAS_HIGH_CYC  = hts_pkg::MEAS_HIGH_CYC,
  parameter int          MEAS_MED_CYC   = hts_pkg::MEAS_MED_CYC,
  parameter int          MEAS_LOW_CYC   = hts_pkg::MEAS_LOW_CYC,
  parameter int          HEAT_LONG_CYC  = hts_pkg::HEAT_LONG_CYC,
  parameter int          HEAT_SHORT_CYC = hts_pkg::HEAT_SHORT_CYC,
  parameter logic [6:0]  DEV_ADDR       = hts_pkg::DEV_ADDR_DEFAULT,
  parameter logic [31:0] SERIAL_ID      = hts_pkg::SERIAL_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [15:0] temp_code_i,
  input  wire logic [15:0] raw_humidity_code_i,
  output logic             heater_on_o,
  output logic      [1:0]  heater_level_o,
  output logic             measuring_o,
  output logic             busy_o,
  output logic             data_ready_o
);

  localparam int CW = hts_pkg::CNT_W;
  localparam logic [CW-1:0] MEAS_H_LOAD = CW'(MEAS_HIGH_CYC - 1);
  localparam logic [CW-1:0] MEAS_M_LOAD = CW'(MEAS_MED_CYC - 1);
  localparam logic [CW-1:0] MEAS_L_LOAD = CW'(MEAS_LOW_CYC - 1);
  // heating plus the final measurement fit inside the pulse length
  localparam logic [CW-1:0] HEAT_L_LOAD =
    CW'(HEAT_LONG_CYC - MEAS_HIGH_CYC - 1);
  localparam logic [CW-1:0] HEAT_S_LOAD =
    CW'(HEAT_SHORT_CYC - MEAS_HIGH_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK, S_RNEXT
  } hts_bus_st_type;

  typedef enum logic [1:0] {
    A_IDLE, A_HEAT, A_MEAS, A_DONE
  } hts_act_st_type;

  // ****************************************************************
  // pin synchronisers and bus conditions
  // ****************************************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_s;
  logic       sda_s;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_p_q    <= scl_sync_q[1];
      sda_p_q    <= sda_sync_q[1];
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign rise  = scl_s & ~scl_p_q;
  assign fall  = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************************************
  // result words and transmit bytes
  // ****************************************************************
  logic [15:0] w0_q, w0_d;
  logic [15:0] w1_q, w1_d;
  logic [7:0]  crc0;
  logic [7:0]  crc1;
  logic [15:0] words [2];

  assign words[0] = w0_q;
  assign words[1] = w1_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_crc
      if (g == 0) begin : g_w0
        hts_crc8 u_crc (.data_i(words[g]), .crc_o(crc0));
      end else begin : g_w1
        hts_crc8 u_crc (.data_i(words[g]), .crc_o(crc1));
      end
    end
  endgenerate

  function automatic logic [7:0] tx_byte(input logic [2:0] idx,
                                         input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [7:0] ca,
                                         input logic [7:0] cb);
    case (idx)
      3'h0:    tx_byte = a[15:8];
      3'h1:    tx_byte = a[7:0];
      3'h2:    tx_byte = ca;
      3'h3:    tx_byte = b[15:8];
      3'h4:    tx_byte = b[7:0];
      3'h5:    tx_byte = cb;
      default: tx_byte = hts_pkg::IDLE_BYTE;
    endcase
  endfunction : tx_byte

  // ****************************************************************
  // bus slave
  // ****************************************************************
  hts_bus_st_type st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic       ph_q, ph_d;
  logic       oe_q, oe_d;
  logic       ack_q, ack_d;
  logic       rd_q, rd_d;
  logic       gc_q, gc_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] rx_byte;
  logic       cmd_fire;
  logic       hdr_ack;
  logic       own_hit;
  logic       valid_q, valid_d;
  logic       busy_q;

  assign rx_byte = {sh_q[6:0], sda_s};
  assign own_hit = (rx_byte[7:1] == DEV_ADDR);

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    ph_d     = ph_q;
    oe_d     = oe_q;
    ack_d    = ack_q;
    rd_d     = rd_q;
    gc_d     = gc_q;
    idx_d    = idx_q;
    cmd_fire = 1'b0;
    hdr_ack  = 1'b0;
    if (start) begin
      st_d  = S_ADDR;
      bit_d = 3'h0;
      oe_d  = 1'b0;
    end else if (stop) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          oe_d = 1'b0;
        end
        S_ADDR: begin
          if (rise) begin
            sh_d  = rx_byte;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              rd_d  = rx_byte[0];
              gc_d  = (rx_byte == {hts_pkg::GC_ADDR, 1'b0});
              // no stretching: a busy or empty sensor refuses the read
              ack_d = gc_d | (own_hit & ~rx_byte[0]) |
                      (own_hit & rx_byte[0] & valid_q & ~busy_q);
              hdr_ack = own_hit & rx_byte[0] & valid_q & ~busy_q;
              sh_d  = tx_byte(3'h0, w0_q, w1_q, crc0, crc1);
              idx_d = 3'h0;
              ph_d  = 1'b0;
              st_d  = S_AACK;
            end
          end
        end
        S_AACK: begin
          if (fall) begin
            if (!ph_q) begin
              oe_d = ack_q;
              ph_d = 1'b1;
            end else if (!ack_q) begin
              oe_d = 1'b0;
              st_d = S_IDLE;
            end else if (rd_q) begin
              oe_d  = ~sh_q[7];
              bit_d = 3'h0;
              st_d  = S_RDATA;
            end else begin
              oe_d  = 1'b0;
              bit_d = 3'h0;
              st_d  = S_WDATA;
            end
          end
        end
        S_WDATA: begin
          if (rise) begin
            sh_d  = rx_byte;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              cmd_fire = 1'b1;
              ph_d     = 1'b0;
              st_d     = S_WACK;
            end
          end
        end
        S_WACK: begin
          if (fall) begin
            if (!ph_q) begin
              oe_d = 1'b1;
              ph_d = 1'b1;
            end else begin
              oe_d  = 1'b0;
              bit_d = 3'h0;
              st_d  = S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              ph_d = 1'b0;
              st_d = S_RACK;
            end
          end else if (fall) begin
            oe_d = ~sh_q[3'h7 - bit_q];
          end
        end
        S_RACK: begin
          if (fall && !ph_q) begin
            oe_d = 1'b0;
            ph_d = 1'b1;
          end else if (rise && ph_q) begin
            if (sda_s) begin
              st_d = S_IDLE;
            end else begin
              idx_d = idx_q + 3'h1;
              sh_d  = tx_byte(idx_q + 3'h1, w0_q, w1_q, crc0, crc1);
              st_d  = S_RNEXT;
            end
          end
        end
        S_RNEXT: begin
          if (fall) begin
            oe_d  = ~sh_q[7];
            bit_d = 3'h0;
            st_d  = S_RDATA;
          end
        end
        default: begin
          st_d = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q  <= S_IDLE;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      ph_q  <= 1'b0;
      oe_q  <= 1'b0;
      ack_q <= 1'b0;
      rd_q  <= 1'b0;
      gc_q  <= 1'b0;
      idx_q <= 3'h0;
    end else begin
      st_q  <= st_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      ph_q  <= ph_d;
      oe_q  <= oe_d;
      ack_q <= ack_d;
      rd_q  <= rd_d;
      gc_q  <= gc_d;
      idx_q <= idx_d;
    end
  end

  // ****************************************************************
  // action sequencer: measurement, heater, serial number
  // ****************************************************************
  hts_act_st_type a_q, a_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          heat_q, heat_d;
  logic [1:0]    lvl_q, lvl_d;
  logic          own_cmd;
  logic          abort;
  logic          heat_cmd;
  logic          sda_q;
  logic          meas_q;

  assign own_cmd = cmd_fire & ~gc_q;
  assign abort   = cmd_fire & ((gc_q & (rx_byte == hts_pkg::GC_RESET)) |
                   (~gc_q & (rx_byte == hts_pkg::CMD_SOFT_RST)));
  assign heat_cmd = own_cmd & (a_q == A_IDLE) &
                    (rx_byte inside {hts_pkg::CMD_HEAT_200_L,
                     hts_pkg::CMD_HEAT_200_S, hts_pkg::CMD_HEAT_110_L,
                     hts_pkg::CMD_HEAT_110_S, hts_pkg::CMD_HEAT_20_L,
                     hts_pkg::CMD_HEAT_20_S});

  always_comb begin
    a_d     = a_q;
    cnt_d   = cnt_q;
    heat_d  = heat_q;
    lvl_d   = lvl_q;
    valid_d = valid_q & ~hdr_ack;
    w0_d    = w0_q;
    w1_d    = w1_q;
    case (a_q)
      A_IDLE: begin
        if (own_cmd) begin
          case (rx_byte)
            hts_pkg::CMD_MEAS_HIGH: begin
              cnt_d = MEAS_H_LOAD;
              a_d   = A_MEAS;
            end
            hts_pkg::CMD_MEAS_MED: begin
              cnt_d = MEAS_M_LOAD;
              a_d   = A_MEAS;
            end
            hts_pkg::CMD_MEAS_LOW: begin
              cnt_d = MEAS_L_LOAD;
              a_d   = A_MEAS;
            end
            hts_pkg::CMD_SERIAL: begin
              w0_d    = SERIAL_ID[31:16];
              w1_d    = SERIAL_ID[15:0];
              valid_d = 1'b1;
            end
            hts_pkg::CMD_HEAT_200_L, hts_pkg::CMD_HEAT_110_L,
            hts_pkg::CMD_HEAT_20_L: begin
              cnt_d = HEAT_L_LOAD;
            end
            hts_pkg::CMD_HEAT_200_S, hts_pkg::CMD_HEAT_110_S,
            hts_pkg::CMD_HEAT_20_S: begin
              cnt_d = HEAT_S_LOAD;
            end
            default: begin
              a_d = A_IDLE;
            end
          endcase
          case (rx_byte)
            hts_pkg::CMD_HEAT_200_L, hts_pkg::CMD_HEAT_200_S:
              lvl_d = hts_pkg::LVL_200;
            hts_pkg::CMD_HEAT_110_L, hts_pkg::CMD_HEAT_110_S:
              lvl_d = hts_pkg::LVL_110;
            hts_pkg::CMD_HEAT_20_L, hts_pkg::CMD_HEAT_20_S:
              lvl_d = hts_pkg::LVL_20;
            default:
              lvl_d = lvl_q;
          endcase
          if (heat_cmd) begin
            heat_d = 1'b1;
            a_d    = A_HEAT;
          end
          if (a_d != A_IDLE) begin
            valid_d = 1'b0;
          end
        end
      end
      A_HEAT: begin
        if (cnt_q == '0) begin
          cnt_d = MEAS_H_LOAD;
          a_d   = A_MEAS;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      A_MEAS: begin
        if (cnt_q == '0) begin
          heat_d = 1'b0;
          lvl_d  = hts_pkg::LVL_OFF;
          w0_d   = temp_code_i;
          w1_d   = raw_humidity_code_i;
          a_d    = A_DONE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      A_DONE: begin
        valid_d = 1'b1;
        a_d     = A_IDLE;
      end
      default: begin
        a_d = A_IDLE;
      end
    endcase
    // the only way to stop heating early is a reset
    if (abort) begin
      a_d     = A_IDLE;
      heat_d  = 1'b0;
      lvl_d   = hts_pkg::LVL_OFF;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      a_q     <= A_IDLE;
      cnt_q   <= '0;
      heat_q  <= 1'b0;
      lvl_q   <= hts_pkg::LVL_OFF;
      valid_q <= 1'b0;
      w0_q    <= 16'h0000;
      w1_q    <= 16'h0000;
      busy_q  <= 1'b0;
      meas_q  <= 1'b0;
      sda_q   <= 1'b0;
    end else begin
      a_q     <= a_d;
      cnt_q   <= cnt_d;
      heat_q  <= heat_d;
      lvl_q   <= lvl_d;
      valid_q <= valid_d;
      w0_q    <= w0_d;
      w1_q    <= w1_d;
      busy_q  <= (a_d != A_IDLE);
      meas_q  <= (a_d == A_MEAS);
      sda_q   <= 1'b0;
    end
  end

  assign sda_o          = sda_q;
  assign sda_oe_o       = oe_q;
  assign heater_on_o    = heat_q;
  assign heater_level_o = lvl_q;
  assign measuring_o    = meas_q;
  assign busy_o         = busy_q;
  assign data_ready_o   = valid_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [CW-1:0] hon_q;

  always_ff @(posedge clk_i) begin
    if (srst_i || !heat_q) begin
      hon_q <= '0;
    end else begin
      hon_q <= hon_q + CW'(1);
    end
  end

  a_heat_max_time: assert property (@(posedge clk_i) disable iff (srst_i)
    hon_q < CW'(HEAT_LONG_CYC)) else $error("heater on too long");

  a_reset_abort: assert property (@(posedge clk_i) disable iff (srst_i)
    abort |=> (a_q == A_IDLE) && !heat_q && !valid_q && !busy_q)
    else $error("reset did not abort action");

  a_gc_reset: assert property (@(posedge clk_i) disable iff (srst_i)
    (cmd_fire && gc_q && rx_byte == hts_pkg::GC_RESET) |=> !busy_q)
    else $error("general call reset ignored");

  a_soft_reset: assert property (@(posedge clk_i) disable iff (srst_i)
    (own_cmd && rx_byte == hts_pkg::CMD_SOFT_RST) |=> !heat_q && !valid_q)
    else $error("soft reset ignored");

  a_heat_start: assert property (@(posedge clk_i) disable iff (srst_i)
    heat_cmd && !abort |=> heat_q && (a_q == A_HEAT) && lvl_q != 2'h0)
    else $error("heater command not started");

  a_heat_code_map: assert property (@(posedge clk_i) disable iff (srst_i)
    (heat_cmd && rx_byte == hts_pkg::CMD_HEAT_20_S) |=>
      lvl_q == hts_pkg::LVL_20 && cnt_q == HEAT_S_LOAD)
    else $error("heater code mapped wrongly");

  a_heat_only_cmd: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(heat_q) |-> $past(heat_cmd)) else $error("heater on without command");

  a_heat_to_meas: assert property (@(posedge clk_i) disable iff (srst_i)
    (a_q == A_HEAT && cnt_q == '0 && !abort) |=>
      a_q == A_MEAS && heat_q && cnt_q == MEAS_H_LOAD)
    else $error("measurement not started after heating");

  a_meas_end_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (a_q == A_MEAS && cnt_q == '0 && !abort) |=> !heat_q ##1 valid_q)
    else $error("heater not off before data ready");

  a_busy_nack: assert property (@(posedge clk_i) disable iff (srst_i)
    (st_q == S_ADDR && rise && !start && !stop && bit_q == 3'h7 && own_hit &&
     rx_byte[0] && busy_q) |=> !ack_q ##0 !oe_q)
    else $error("busy sensor acknowledged read");

  a_read_once: assert property (@(posedge clk_i) disable iff (srst_i)
    (hdr_ack && !start && !stop && !own_cmd) |=> !valid_q)
    else $error("result not dropped after read");

  a_serial_load: assert property (@(posedge clk_i) disable iff (srst_i)
    (own_cmd && a_q == A_IDLE && rx_byte == hts_pkg::CMD_SERIAL && !abort)
      |=> valid_q && w0_q == SERIAL_ID[31:16] && w1_q == SERIAL_ID[15:0])
    else $error("serial words wrong");

  a_crc_check: assert property (@(posedge clk_i) disable iff (srst_i)
    (w0_q == hts_pkg::CRC_CHECK_WORD) |-> crc0 == hts_pkg::CRC_CHECK_VAL)
    else $error("checksum wrong");

endmodule : hts_sensor_core
`default_nettype wire

/* File: testbench/hts_host_model.sv */
// bus master model driving the sensor clock and data pins
`timescale 1ns/1ns
`default_nettype none
module hts_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // ********
  // bit and byte level bus cycles, five clocks per phase
  // ********
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic start();
    sda_oe_o <= 1'b0;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_oe_o <= 1'b1;
    tick(5);
    scl_o <= 1'b0;
    tick(5);
  endtask : start
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    sda_oe_o <= 1'b0;
    tick(5);
  endtask : stop
  // released data reads back high through the pull-up
  task automatic bit_io(input logic b, output logic s);
    sda_oe_o <= ~b;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    s = sda_i;
    scl_o <= 1'b0;
    tick(5);
  endtask : bit_io
  task automatic xfer(input logic [7:0] w, input logic nak,
                      output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], s);
      r[i] = s;
    end
    bit_io(nak, s);
    ack = ~s;
  endtask : xfer
  // power removal: both lines held low while the supply is off
  task automatic power_down(input int n);
    scl_o    <= 1'b0;
    sda_oe_o <= 1'b1;
    tick(n);
    scl_o    <= 1'b1;
    sda_oe_o <= 1'b0;
    tick(n);
  endtask : power_down
  // host-side conversion of a raw code to hundredths of a unit
  function automatic int conv(input logic [15:0] c, input int base,
                              input int span, input logic clamp);
    int v;
    v = base * 100 + span * 100 * int'(c) / 65535;
    if (clamp && v < 0) v = 0;
    if (clamp && v > 10000) v = 10000;
    return v;
  endfunction : conv
endmodule : hts_host_model
`default_nettype wire

/* File: testbench/tb_humidity_temp_sensor_cmd_heater.sv */
// self-checking bench for the sensor command core
`timescale 1ns/1ns
`default_nettype none
module tb_humidity_temp_sensor_cmd_heater;
  localparam int MH = 400;
  localparam int HS = 700;
  localparam logic [6:0] DA = hts_pkg::DEV_ADDR_DEFAULT;
  localparam logic [31:0] SID = hts_pkg::SERIAL_DEFAULT;
  localparam logic [7:0] MCMD [4] = '{8'hfd, 8'hf6, 8'he0, 8'h15};
  localparam logic [7:0] HCMD [6] = '{8'h39, 8'h32, 8'h2f, 8'h24,
                                      8'h1e, 8'h15};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] tcode = 16'h0;
  logic [15:0] hcode = 16'h0;
  logic        scl, host_oe, dev_oe, hon, rdy, meas, busy, sdo;
  logic [1:0]  lvl;
  wire         sda;
  logic [7:0]  q[$];
  int          fail_count = 0, checks = 0, hon_n = 0, mh_n = 0, late_n = 0;
  int          cyc_n = 0;
  assign sda = ~(dev_oe | host_oe);
  always #25 clk = ~clk;
  always @(negedge clk) begin
    hon_n += hon;
    mh_n += hon & meas;
    late_n += hon & rdy;
    cyc_n++;
  end
  hts_sensor_core #(.MEAS_HIGH_CYC(MH), .MEAS_MED_CYC(350),
    .MEAS_LOW_CYC(300), .HEAT_LONG_CYC(1000), .HEAT_SHORT_CYC(HS)) uut (
    .clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_o(dev_oe), .temp_code_i(tcode), .raw_humidity_code_i(hcode),
    .heater_on_o(hon), .heater_level_o(lvl), .measuring_o(meas),
    .busy_o(busy), .data_ready_o(rdy));
  hts_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(host_oe));
  // ********
  // checking helpers
  // ********
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc
  task automatic push(input logic [15:0] w);
    q.push_back(w[15:8]);
    q.push_back(w[7:0]);
    q.push_back(crc(w));
  endtask : push
  task automatic cmd(input logic [6:0] a, input logic [7:0] c);
    logic [7:0] r;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, r, k);
    chk("write header ack", 1'b1, k);
    host.xfer(c, 1'b1, r, k);
    chk("command ack", 1'b1, k);
    host.stop();
  endtask : cmd
  task automatic rd(input logic ok);
    logic [7:0] r;
    logic k, j;
    host.start();
    host.xfer({DA, 1'b1}, 1'b1, r, k);
    chk("read header ack", ok, k);
    for (int i = 0; ok && k && i < 6; i++) begin
      host.xfer(8'hff, i == 5, r, j);
      chk("read byte", q.pop_front(), r);
    end
    host.stop();
  endtask : rd
  task automatic wait_idle();
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n > 3000) begin
        fail_count++;
        results();
      end
      @(posedge clk);
    end
  endtask : wait_idle
  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'h1f53));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    host.tick(5);
    cmd(DA, 8'h89);
    push(SID[31:16]);
    push(SID[15:0]);
    rd(1'b1);
    for (int i = 0; i < 4; i++) begin
      tcode <= (i == 0) ? 16'hbeef : 16'($urandom);
      hcode <= 16'($urandom);
      cmd(DA, MCMD[i]);
      rd(1'b0);
      wait_idle();
      host.tick(2);
      chk("ready", 1'b1, rdy);
      push(tcode);
      push(hcode);
      rd(1'b1);
      rd(1'b0);
    end
    chk("heater cycles", HS, hon_n);
    chk("heated measure", MH, mh_n);
    chk("heater at ready", 0, late_n);
    for (int i = 0; i < 6; i++) begin
      cmd(DA, HCMD[i]);
      chk("heater on", 1'b1, hon);
      chk("heater level", 3 - i / 2, lvl);
      if (i % 2 == 1) cmd(7'h00, 8'h06);
      else cmd(DA, 8'h94);
      host.tick(2);
      chk("aborted", 5'h0, {hon, lvl, busy, rdy});
      // idle gap long enough to keep the heater duty under ten percent
      host.tick(4000);
    end
    cmd(DA, HCMD[0]);
    chk("heater on", 1'b1, hon);
    srst <= 1'b1;
    host.power_down(4);
    srst <= 1'b0;
    host.tick(2);
    chk("power reset", 7'h0, {hon, lvl, busy, rdy, dev_oe, sdo});
    cmd(DA, 8'h89);
    push(SID[31:16]);
    push(SID[15:0]);
    rd(1'b1);
    chk("rh min", 0, host.conv(16'h0000, -6, 125, 1'b1));
    chk("rh max", 10000, host.conv(16'hffff, -6, 125, 1'b1));
    chk("deg c", 13000, host.conv(16'hffff, -45, 175, 1'b0));
    chk("deg f", -4900, host.conv(16'h0000, -49, 315, 1'b0));
    chk("heater duty", 1'b1, hon_n * 10 < cyc_n);
    results();
  end
endmodule : tb_humidity_temp_sensor_cmd_heater
`default_nettype wire
